// ===== bench/swri_host_model.sv
// Local control processor model: an Avalon-MM master for the registers.
`timescale 1ns/1ns
module swri_host_model
  import swri_pkg::*;
(
  input wire logic clock,
  output logic [swri_pkg::AW-1:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [swri_pkg::DW-1:0] avs_writedata,
  output logic [3:0] avs_byteenable,
  input wire logic [swri_pkg::DW-1:0] avs_readdata,
  input wire logic avs_waitrequest
);
  // The bus is idle from time zero; all lanes are always enabled.
  initial begin
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    avs_byteenable = 4'hf;
  end
  // One access; the request is held until waitrequest is sampled low.
  task automatic acc(input logic w, input logic [7:0] a,
    input logic [31:0] dt, output logic [31:0] q);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= dt;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
endmodule

// ===== bench/swri_top_sva.sv
// Port checks for the switch reset and expansion init block.
`timescale 1ns/1ns
module swri_top_sva
  import swri_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic poweron_reset_input_n,
  input wire logic [swri_pkg::AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [swri_pkg::DW-1:0] avs_writedata,
  input wire logic avs_waitrequest,
  input wire logic [swri_pkg::ADDRW-1:0] store_addr_local,
  input wire logic [swri_pkg::ADDRW-1:0] store_addr_up,
  input wire logic [swri_pkg::ADDRW-1:0] store_addr_out,
  input wire logic [swri_pkg::RST_USED-1:0] reset_ctrl,
  input wire logic slave_ctrl_clk_en,
  input wire logic [swri_pkg::DW-1:0] global_link,
  input wire logic thresh_wr,
  input wire logic exp_prog_done
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic wdone;
  logic [31:0] wd_r;
  // A write completes at the edge where waitrequest is seen low.
  assign wdone = avs_write && !avs_waitrequest;
  // Outputs lag the write by a register, so the data is kept for them.
  always_ff @(posedge clock) begin
    if (wdone) begin
      wd_r <= avs_writedata;
    end
  end
  a_wait_one: assert property (
    (avs_read || avs_write) && avs_waitrequest |=>
    !avs_waitrequest ##1 avs_waitrequest) else $error("wait not one cycle");
  a_thresh_strobe: assert property (
    wdone && avs_address == OFS_THRESH |-> ##[1:2] thresh_wr)
    else $error("no threshold strobe");
  a_glink_copy: assert property (
    wdone && avs_address == OFS_GLINK && poweron_reset_input_n
    |-> ##[1:2] global_link == wd_r) else $error("global link stale");
  a_reset_copy: assert property (
    wdone && avs_address == OFS_RESET && poweron_reset_input_n
    |-> ##[1:2] reset_ctrl == wd_r[7:0]) else $error("reset ctrl stale");
  a_done_copy: assert property (
    wdone && avs_address == OFS_LAT_PROG
    |-> ##[1:2] exp_prog_done == wd_r[LP_DONE]) else $error("done stale");
  a_poweron_init: assert property (
    !poweron_reset_input_n && !wdone |-> ##[1:2]
    reset_ctrl == RESET_REG_INIT && global_link == GLINK_INIT)
    else $error("power-on reset ignored");
  a_clk_gate: assert property (
    !reset_ctrl[RST_FLUSH_CTRL] [*2] |-> slave_ctrl_clk_en)
    else $error("control clock stopped without flush control");
  a_store_fwd: assert property (
    1'b1 |=> store_addr_out == $past(store_addr_up)
    || store_addr_out == $past(store_addr_local))
    else $error("store address not forwarded");
endmodule

bind swri_top swri_top_sva i_sva (.clock, .sys_rst, .poweron_reset_input_n,
  .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_waitrequest,
  .store_addr_local, .store_addr_up, .store_addr_out, .reset_ctrl,
  .slave_ctrl_clk_en, .global_link, .thresh_wr, .exp_prog_done);

// ===== bench/swri_top_tb_top.sv
// Self-checking bench of the switch reset and expansion init block.
`timescale 1ns/1ns
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  mismatches++; $display("unexpected %s: expected %h, seen %h", n, e, g); \
  end end
module swri_top_tb_top;
  import swri_pkg::*;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic poweron_reset_input_n = 1'b1;
  logic core_pll_locked = 1'b1, link_pll_locked = 1'b0;
  logic [NUNLOCK-1:0] link_pll_unlock = 4'h5;
  logic [NEV-1:0] event_in = '0, code_viol_in = '0;
  logic [NLINK*DLYW-1:0] link_delay = '0;
  logic [ADDRW-1:0] s_loc = 12'h123, s_up = 12'h456;
  logic [ADDRW-1:0] r_loc = 12'h789, r_up = 12'habc;
  logic [AW-1:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest;
  logic [DW-1:0] avs_writedata, avs_readdata, global_link, thresh_data, q;
  logic [3:0] avs_byteenable;
  logic [ADDRW-1:0] store_addr_out, retrieve_addr_out;
  logic [RST_USED-1:0] reset_ctrl;
  logic slave_ctrl_clk_en, thresh_wr, exp_prog_done;
  logic [NLINK*LATW-1:0] link_latency;
  int mismatches = 0, samples_checked = 0, cycles = 0, l, d;
  swri_host_model i_host (.clock, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest);
  swri_top i_dut (.clock, .sys_rst, .poweron_reset_input_n, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .core_pll_locked, .link_pll_locked, .link_pll_unlock,
    .event_in, .code_viol_in, .link_delay, .store_addr_local(s_loc),
    .store_addr_up(s_up), .retrieve_addr_local(r_loc),
    .retrieve_addr_up(r_up), .store_addr_out, .retrieve_addr_out,
    .reset_ctrl, .slave_ctrl_clk_en, .global_link, .thresh_data,
    .thresh_wr, .link_latency, .exp_prog_done);
  // Free-running 100 MHz clock.
  initial begin
    forever #5 clock = ~clock;
  end
  // A hang is cut short well after the whole sequence should be over.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] dt);
    logic [31:0] r;
    i_host.acc(1'b1, a, dt, r);
  endtask
  // Plain read; the caller checks the fields of q that it cares about.
  task automatic rd(input logic [7:0] a);
    i_host.acc(1'b0, a, 32'h0, q);
  endtask
  task automatic rdc(input string n, input logic [7:0] a,
    input logic [31:0] e);
    i_host.acc(1'b0, a, 32'h0, q);
    `CHK(n, e, q)
  endtask
  // Registered outputs need two edges to show a completed write.
  task automatic hold2();
    repeat (2) @(posedge clock);
  endtask
  // Latency bin from a delay: bins are one unit length wide.
  function automatic int ebin(int dl, int ln);
    ebin = 1;
    for (int k = 1; k < 6; k++) begin
      ebin += (dl > 2 + k * ln);
    end
  endfunction
  // Bring-up, interrupts and deskew, expansion latency, then power-on reset.
  initial begin
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    rdc("reset reg", OFS_RESET, {24'h0, RESET_REG_INIT});
    wr(OFS_RESET, 32'hde);
    wr(OFS_RESET, 32'hdc);
    rdc("pll locked", OFS_PLL_STAT, 32'h1);
    link_pll_locked <= 1'b1;
    rdc("pll locked", OFS_PLL_STAT, 32'h3);
    wr(OFS_GLINK, 32'hf0000000);
    wr(OFS_RESET, 32'hd8);
    `CHK("global link", 32'hf0000000, global_link)
    rdc("unlock", OFS_LINK_ERR, 32'h5);
    link_pll_unlock <= '0;
    rdc("unlock", OFS_LINK_ERR, 32'h0);
    wr(OFS_RESET, 32'he0);
    hold2();
    `CHK("reset ctrl", 8'he0, reset_ctrl)
    wr(OFS_CONFIG, 32'h10);
    wr(OFS_RESET, 32'he8);
    hold2();
    `CHK("ctrl clock", 1'b0, slave_ctrl_clk_en)
    wr(OFS_RESET, 32'he0);
    wr(OFS_CONFIG, 32'h0);
    hold2();
    `CHK("ctrl clock", 1'b1, slave_ctrl_clk_en)
    wr(OFS_THRESH, 32'h12345678);
    hold2();
    `CHK("threshold", 32'h12345678, thresh_data)
    rdc("threshold", OFS_THRESH, 32'h12345678);
    wr(OFS_RESET, 32'ha0);
    done("bring-up");
    event_in <= 16'h8001;
    code_viol_in <= 16'h0003;
    @(posedge clock);
    event_in <= '0;
    code_viol_in <= '0;
    rdc("status", OFS_STATUS, 32'h8001);
    rdc("status", OFS_STATUS, 32'h0);
    rdc("code viol", OFS_CODE_VIOL, 32'h3);
    rdc("code viol", OFS_CODE_VIOL, 32'h0);
    wr(OFS_RESET, 32'h20);
    wr(OFS_GLINK, 32'hf00088c4);
    rdc("global link", OFS_GLINK, 32'hf00088c4);
    wr(8'h3c, 32'hffffffff);
    rdc("unmapped", 8'h3c, 32'h0);
    `CHK("store fwd", 12'h123, store_addr_out)
    `CHK("retrieve fwd", 12'h789, retrieve_addr_out)
    done("interrupts and deskew");
    for (int u = 0; u < 3; u++) begin
      for (int j = 0; j < 4; j++) begin
        l = 8 + u;
        d = (j < 2) ? 2 + l + j : 2 + 6 * l + j - 2;
        link_delay[0+:DLYW] <= DLYW'(d);
        link_delay[8*DLYW+:DLYW] <= DLYW'(d);
        wr(OFS_CONFIG, 32'h610 | u);
        wr(OFS_LAT_PROG, 32'h0);
        rd(OFS_LAT_PROG);
        `CHK("link sel", 4'h0, q[3:0])
        `CHK("delay", DLYW'(d), q[LP_DLY_LSB+:DLYW])
        `CHK("too slow", d > 2 + 6 * l, q[LP_ERR])
        if (d <= 2 + 6 * l) begin
          `CHK("ingress", 3'(ebin(d, l)), q[LP_SUG_LSB+:3])
          wr(OFS_LAT_PROG, 32'h8);
          rd(OFS_LAT_PROG);
          `CHK("link sel", 4'h8, q[3:0])
          `CHK("egress", 3'(6 - ebin(d, l)), q[LP_SUG_LSB+:3])
        end
      end
    end
    `CHK("store fwd", 12'h456, store_addr_out)
    `CHK("retrieve fwd", 12'habc, retrieve_addr_out)
    wr(OFS_LAT_PROG, 32'h580);
    rd(OFS_LAT_PROG);
    `CHK("link sel", 4'h0, q[3:0])
    `CHK("stored lat", 3'h5, q[LP_CUR_LSB+:3])
    `CHK("slave lat", 3'h5, link_latency[2:0])
    wr(OFS_CONFIG, 32'h600);
    hold2();
    `CHK("master in", 3'h0, link_latency[2:0])
    `CHK("master out", 3'h6, link_latency[26:24])
    wr(OFS_CONFIG, 32'h630);
    hold2();
    `CHK("last out", 3'h0, link_latency[26:24])
    wr(OFS_LAT_PROG, 32'h10000);
    rd(OFS_LAT_PROG);
    `CHK("link sel", 4'h0, q[3:0])
    `CHK("prog done", 1'b1, q[LP_DONE_RD])
    `CHK("prog done", 1'b1, exp_prog_done)
    done("latency");
    poweron_reset_input_n <= 1'b0;
    repeat (3) @(posedge clock);
    poweron_reset_input_n <= 1'b1;
    hold2();
    `CHK("reset ctrl", RESET_REG_INIT, reset_ctrl)
    `CHK("global link", GLINK_INIT, global_link)
    rdc("config", OFS_CONFIG, {16'h0000, CONFIG_INIT});
    done("power-on reset");
    end_of_test();
  end
endmodule

// ===== inc/swri_pkg.sv
// Constants shared by the switch reset and expansion init block.
package swri_pkg;
  localparam int unsigned AW = 8;
  localparam int unsigned DW = 32;
  localparam int unsigned NLINK = 16;
  localparam int unsigned NHALF = 8;
  localparam int unsigned DLYW = 7;
  localparam int unsigned LATW = 3;
  localparam int unsigned ADDRW = 12;
  localparam int unsigned NEV = 16;
  localparam int unsigned NUNLOCK = 4;
  // Register byte offsets.
  localparam logic [7:0] OFS_RESET = 8'h00;
  localparam logic [7:0] OFS_PLL_STAT = 8'h04;
  localparam logic [7:0] OFS_GLINK = 8'h08;
  localparam logic [7:0] OFS_LINK_ERR = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_THRESH = 8'h14;
  localparam logic [7:0] OFS_CODE_VIOL = 8'h18;
  localparam logic [7:0] OFS_LAT_PROG = 8'h1c;
  localparam logic [7:0] OFS_CONFIG = 8'h20;
  // Reset register bit positions.
  localparam int unsigned RST_CORE_PLL = 0;
  localparam int unsigned RST_LINK_PLL = 1;
  localparam int unsigned RST_MACRO_FLUSH = 2;
  localparam int unsigned RST_FLUSH_CTRL = 3;
  localparam int unsigned RST_FLUSH = 4;
  localparam int unsigned RST_DRV_EN = 5;
  localparam int unsigned RST_STANDBY = 6;
  localparam int unsigned RST_INT_MASK = 7;
  localparam int unsigned RST_USED = 8;
  // Values after reset.
  localparam logic [7:0] RESET_REG_INIT = 8'hdf;
  localparam logic [31:0] GLINK_INIT = 32'h00000000;
  localparam logic [15:0] CONFIG_INIT = 16'h0000;
  // Configuration register fields.
  localparam int unsigned CFG_ULEN_LSB = 0;
  localparam int unsigned CFG_SLAVE = 4;
  localparam int unsigned CFG_LAST = 5;
  localparam int unsigned CFG_MAXLAT_LSB = 8;
  localparam int unsigned CFG_USED = 16;
  // Latency programming register fields.
  localparam int unsigned LP_SEL_LSB = 0;
  localparam int unsigned LP_UPD = 7;
  localparam int unsigned LP_VAL_LSB = 8;
  localparam int unsigned LP_DONE = 16;
  localparam int unsigned LP_DLY_LSB = 8;
  localparam int unsigned LP_SUG_LSB = 16;
  localparam int unsigned LP_ERR = 19;
  localparam int unsigned LP_DONE_RD = 20;
  localparam int unsigned LP_CUR_LSB = 24;
  // Delay bins: first bin ends at BIN_OFS plus one unit length.
  localparam int unsigned ULEN_BASE = 8;
  localparam int unsigned BIN_OFS = 2;
  localparam int unsigned NBIN = 6;
endpackage

// ===== verilog/swri_lat_bin.sv
// Maps a measured expansion delay to a latency bin and an error flag.
`timescale 1ns/1ns
module swri_lat_bin
  import swri_pkg::*;
(
  input wire logic [swri_pkg::DLYW-1:0] delay,
  input wire logic [1:0] ulen_code,
  output logic [swri_pkg::LATW-1:0] bin,
  output logic too_slow
);
  logic [7:0] ulen;
  logic [NBIN-1:0] above;

  // Unit length in bytes; code three is not a legal length and gives 11.
  assign ulen = 8'(ULEN_BASE) + {6'h00, ulen_code};

  // Each threshold is BIN_OFS plus k unit lengths; the bins are that wide.
  genvar k;
  generate
    for (k = 1; k <= NBIN; k++) begin : g_thr
      assign above[k-1] = {1'b0, delay} > 8'(BIN_OFS + k * ulen);
    end
  endgenerate

  // Bin is one plus the thresholds passed below the last one.
  always_comb begin
    bin = 3'h1;
    for (int i = 0; i < NBIN - 1; i++) begin
      bin = bin + {2'h0, above[i]};
    end
  end

  assign too_slow = above[NBIN-1];
endmodule

// ===== verilog/swri_top.sv
// Reset, bring-up control and expansion latency logic of the switch.
// How it works
// - Flush-control on a slave stops its control logic clock.
// - Threshold writes are taken at any time, even while forwarding.
// - Reading the status register clears the interrupts that it returned.
// - Reading code violations clears them; errors read zero later.
// - Store addresses ripple master to slaves; slave data path delayed.
// - Retrieve addresses ripple; all but last slave delay egress data.
// - Master: ingress zero, egress max latency; last slave egress zero.
// - Delay maps to latency 1..6 in unit-length bins; too large errors.
// - Egress slave latency is max latency minus the delay bin.
`timescale 1ns/1ns
module swri_top
  import swri_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic poweron_reset_input_n,
  input wire logic [swri_pkg::AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [swri_pkg::DW-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [swri_pkg::DW-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic core_pll_locked,
  input wire logic link_pll_locked,
  input wire logic [swri_pkg::NUNLOCK-1:0] link_pll_unlock,
  input wire logic [swri_pkg::NEV-1:0] event_in,
  input wire logic [swri_pkg::NLINK-1:0] code_viol_in,
  input wire logic [swri_pkg::NLINK*swri_pkg::DLYW-1:0] link_delay,
  input wire logic [swri_pkg::ADDRW-1:0] store_addr_local,
  input wire logic [swri_pkg::ADDRW-1:0] store_addr_up,
  input wire logic [swri_pkg::ADDRW-1:0] retrieve_addr_local,
  input wire logic [swri_pkg::ADDRW-1:0] retrieve_addr_up,
  output logic [swri_pkg::ADDRW-1:0] store_addr_out,
  output logic [swri_pkg::ADDRW-1:0] retrieve_addr_out,
  output logic [swri_pkg::RST_USED-1:0] reset_ctrl,
  output logic slave_ctrl_clk_en,
  output logic [swri_pkg::DW-1:0] global_link,
  output logic [swri_pkg::DW-1:0] thresh_data,
  output logic thresh_wr,
  output logic [swri_pkg::NLINK*swri_pkg::LATW-1:0] link_latency,
  output logic exp_prog_done
);
  import swri_pkg::*;

  // Merges the enabled byte lanes of a write into the old value.
  function automatic logic [DW-1:0] be_merge(input logic [DW-1:0] old,
                                             input logic [DW-1:0] nw,
                                             input logic [3:0] be);
    logic [DW-1:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return res;
  endfunction

  logic waitreq_r;
  logic [DW-1:0] rdata_r;
  logic [RST_USED-1:0] reset_r;
  logic [DW-1:0] glink_r;
  logic [CFG_USED-1:0] config_r;
  logic [NEV-1:0] status_r;
  logic [NLINK-1:0] cviol_r;
  logic [DW-1:0] thresh_r;
  logic thresh_wr_r;
  logic [3:0] lat_sel_r;
  logic lat_done_r;
  logic [LATW-1:0] lat_prog_r [NLINK];
  logic [NLINK*LATW-1:0] lat_out_r;
  logic [ADDRW-1:0] store_addr_r;
  logic [ADDRW-1:0] retr_addr_r;
  logic slave_clk_en_r;

  // Bus handshake: one wait cycle, then the access completes.
  wire req = avs_read | avs_write;
  wire accept = req & waitreq_r;
  wire done = req & ~waitreq_r;
  wire wr_done = done & avs_write;
  wire rd_done = done & avs_read;
  wire por = ~poweron_reset_input_n;
  wire [DW-1:0] wmerge_reset = be_merge({24'h000000, reset_r},
                                        avs_writedata, avs_byteenable);
  wire [DW-1:0] wmerge_glink = be_merge(glink_r, avs_writedata,
                                        avs_byteenable);
  wire [DW-1:0] wmerge_cfg = be_merge({16'h0000, config_r}, avs_writedata,
                                      avs_byteenable);
  wire [DW-1:0] wmerge_thr = be_merge(thresh_r, avs_writedata,
                                      avs_byteenable);
  wire [DW-1:0] wmerge_lp = be_merge(32'h00000000, avs_writedata,
                                     avs_byteenable);

  // Address decode of the completing access.
  wire hit_reset = avs_address == OFS_RESET;
  wire hit_glink = avs_address == OFS_GLINK;
  wire hit_status = avs_address == OFS_STATUS;
  wire hit_thresh = avs_address == OFS_THRESH;
  wire hit_cviol = avs_address == OFS_CODE_VIOL;
  wire hit_latp = avs_address == OFS_LAT_PROG;
  wire hit_cfg = avs_address == OFS_CONFIG;

  // Role, length and latency fields of the configuration register.
  wire is_slave = config_r[CFG_SLAVE];
  wire is_last = config_r[CFG_LAST];
  wire [1:0] ulen_code = config_r[CFG_ULEN_LSB +: 2];
  wire [LATW-1:0] max_lat = config_r[CFG_MAXLAT_LSB +: LATW];

  // Delay of the link picked by the latency programming register.
  wire [DLYW-1:0] sel_delay = link_delay[lat_sel_r*DLYW +: DLYW];
  wire sel_egress = lat_sel_r >= 4'(NHALF);
  wire [LATW-1:0] sel_bin;
  wire sel_slow;

  swri_lat_bin u_bin (
    .delay(sel_delay),
    .ulen_code(ulen_code),
    .bin(sel_bin),
    .too_slow(sel_slow)
  );

  // Egress suggestion subtracts the bin; ingress uses the bin itself.
  wire [LATW-1:0] sel_suggest = sel_egress ? 3'(max_lat - sel_bin)
                                           : sel_bin;
  wire [DW-1:0] rd_latp = {5'h00, lat_prog_r[lat_sel_r], 3'h0, lat_done_r,
                           sel_slow, sel_suggest, 1'b0, sel_delay,
                           4'h0, lat_sel_r};

  // Read data selection; unmapped offsets read as zero.
  wire [DW-1:0] rd_mux =
    hit_reset ? {24'h000000, reset_r} :
    (avs_address == OFS_PLL_STAT) ? {30'h0, link_pll_locked,
                                     core_pll_locked} :
    hit_glink ? glink_r :
    (avs_address == OFS_LINK_ERR) ? {28'h0, link_pll_unlock} :
    hit_status ? {16'h0000, status_r} :
    hit_thresh ? thresh_r :
    hit_cviol ? {16'h0000, cviol_r} :
    hit_latp ? rd_latp :
    hit_cfg ? {16'h0000, config_r} : 32'h00000000;

  // Sticky flags: a read clears only the bits that it returned, so an
  // event that lands after the data was latched waits for the next read.
  // A new event in the clearing cycle also survives the clear.
  wire [NEV-1:0] status_clr = {NEV{rd_done & hit_status}}
                              & rdata_r[NEV-1:0];
  wire [NLINK-1:0] cviol_clr = {NLINK{rd_done & hit_cviol}}
                               & rdata_r[NLINK-1:0];
  wire [NEV-1:0] status_nxt = (status_r & ~status_clr)
                              | event_in;
  wire [NLINK-1:0] cviol_nxt = (cviol_r & ~cviol_clr)
                               | code_viol_in;

  // Waitrequest and read data; data is latched as the wait ends.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      waitreq_r <= 1'b1;
      rdata_r <= 32'h00000000;
    end else begin
      waitreq_r <= ~accept;
      if (accept && avs_read) begin
        rdata_r <= rd_mux;
      end
    end
  end

  // Control registers written by the host.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      reset_r <= RESET_REG_INIT;
      glink_r <= GLINK_INIT;
      config_r <= CONFIG_INIT;
    end else if (por) begin
      reset_r <= RESET_REG_INIT;
      glink_r <= GLINK_INIT;
      config_r <= CONFIG_INIT;
    end else if (wr_done) begin
      if (hit_reset) begin
        reset_r <= wmerge_reset[RST_USED-1:0];
      end
      if (hit_glink) begin
        glink_r <= wmerge_glink;
      end
      if (hit_cfg) begin
        config_r <= wmerge_cfg[CFG_USED-1:0];
      end
    end
  end

  // Status and code violation flags, cleared by a read.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      status_r <= 16'h0000;
      cviol_r <= 16'h0000;
    end else begin
      status_r <= status_nxt;
      cviol_r <= cviol_nxt;
    end
  end

  // Threshold access has no gating, so traffic need not stop for it.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      thresh_r <= 32'h00000000;
      thresh_wr_r <= 1'b0;
    end else begin
      thresh_wr_r <= wr_done & hit_thresh;
      if (wr_done && hit_thresh) begin
        thresh_r <= wmerge_thr;
      end
    end
  end

  // Link select, done bit and stored latency per link.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      lat_sel_r <= 4'h0;
      lat_done_r <= 1'b0;
      for (int i = 0; i < NLINK; i++) begin
        lat_prog_r[i] <= 3'h0;
      end
    end else if (wr_done && hit_latp) begin
      lat_sel_r <= wmerge_lp[LP_SEL_LSB +: 4];
      lat_done_r <= wmerge_lp[LP_DONE];
      if (wmerge_lp[LP_UPD]) begin
        lat_prog_r[wmerge_lp[LP_SEL_LSB +: 4]] <=
          wmerge_lp[LP_VAL_LSB +: LATW];
      end
    end
  end

  // Latency applied per link; links 0..7 ingress, 8..15 egress.
  wire [NLINK*LATW-1:0] eff_all;
  genvar g;
  generate
    for (g = 0; g < NLINK; g++) begin : g_lat
      localparam bit EGR = g >= NHALF;
      assign eff_all[g*LATW +: LATW] =
        !is_slave ? (EGR ? max_lat : 3'h0) :
        (is_last && EGR) ? 3'h0 :
        lat_prog_r[g];
    end
  endgenerate

  // One register stage for all links, so the vector has a single writer.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      lat_out_r <= 48'h000000000000;
    end else begin
      lat_out_r <= eff_all;
    end
  end

  // Address ripple: master sources, each slave forwards the upstream one.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      store_addr_r <= 12'h000;
      retr_addr_r <= 12'h000;
    end else begin
      store_addr_r <= is_slave ? store_addr_up : store_addr_local;
      retr_addr_r <= is_slave ? retrieve_addr_up
                              : retrieve_addr_local;
    end
  end

  // Flush-control on a slave parks its control logic clock to save power.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      slave_clk_en_r <= 1'b1;
    end else begin
      slave_clk_en_r <= ~(is_slave & reset_r[RST_FLUSH_CTRL]);
    end
  end

  assign avs_waitrequest = waitreq_r;
  assign avs_readdata = rdata_r;
  assign store_addr_out = store_addr_r;
  assign retrieve_addr_out = retr_addr_r;
  assign reset_ctrl = reset_r;
  assign slave_ctrl_clk_en = slave_clk_en_r;
  assign global_link = glink_r;
  assign thresh_data = thresh_r;
  assign thresh_wr = thresh_wr_r;
  assign link_latency = lat_out_r;
  assign exp_prog_done = lat_done_r;
endmodule
